// ### hdl/bsr_bank1_regs.sv
/*
 * Bank-1 special register map with an Avalon-MM slave, reset sets and indirect window.
 * Assumes the core drives ALU flags and program counter updates as synchronous strobes.
 */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ns
`include "bsr_cfg.svh"
module bsr_bank1_regs #(
	parameter int GPR_AW = 8
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic [8:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        brown_out_reset,
	input  wire logic        external_reset_pin_n,
	input  wire logic        wdt_reset,
	input  wire logic        sleep_exec,
	input  wire logic        clrwdt_exec,
	input  wire logic        alu_flags_we,
	input  wire logic [2:0]  alu_flags,
	input  wire logic        pc_low_we,
	input  wire logic [7:0]  pc_low_in,
	input  wire logic [5:0]  serial_port_bus_status_in,
	input  wire logic        trmt_in,
	input  wire logic [2:0]  psp_flags_in,
	output logic [7:0]       option_config,
	output logic [7:0]       port_a_direction,
	output logic [7:0]       port_b_direction,
	output logic [7:0]       port_c_direction,
	output logic [7:0]       port_d_direction,
	output logic [7:0]       slave_port_and_port_e_direction,
	output logic [7:0]       pc_upper_latch,
	output logic [7:0]       peripheral_irq_enable_1,
	output logic [7:0]       peripheral_irq_enable_2,
	output logic [7:0]       timer2_period,
	output logic [7:0]       serial_port_slave_address,
	output logic [7:0]       transmitter_control_status,
	output logic [7:0]       baud_divisor,
	output logic [7:0]       analog_pin_config,
	output logic [7:0]       arith_and_bank_status,
	output logic [7:0]       indirect_address_pointer,
	output logic [7:0]       interrupt_control,
	output logic [7:0]       program_counter_low,
	output logic [1:0]       reset_cause_flags,
	output logic             pc_jump_r,
	output logic [12:0]      pc_target_r
);
	localparam int NS = `BSR_SREG_N;
	// Plain registers: offset, write mask, reset value (same for both reset sets)
	localparam bsr_pkg::bsr_byte_t SR_OFS [NS] = '{`BSR_OFS_OPTION, `BSR_OFS_PORT_A_DIRECTION, `BSR_OFS_PORT_B_DIRECTION,
		`BSR_OFS_PORT_C_DIRECTION, `BSR_OFS_PORT_D_DIRECTION, `BSR_OFS_SLAVE_PORT_AND_PORT_E_DIRECTION, `BSR_OFS_PC_UPPER_LATCH, `BSR_OFS_PERIPHERAL_IRQ_ENABLE_1, `BSR_OFS_PERIPHERAL_IRQ_ENABLE_2,
		`BSR_OFS_PR2, `BSR_OFS_SERIAL_PORT_SLAVE_ADDRESS, `BSR_OFS_TRANSMITTER_CONTROL_STATUS, `BSR_OFS_BAUD_DIVISOR, `BSR_OFS_ANALOG_PIN_CONFIG};
	localparam bsr_pkg::bsr_byte_t SR_WM [NS] = '{`BSR_M_ALL, `BSR_M_PORT_A_DIRECTION, `BSR_M_ALL, `BSR_M_ALL,
		`BSR_M_ALL, `BSR_M_SLAVE_PORT_AND_PORT_E_DIRECTION, `BSR_M_PC_UPPER_LATCH, `BSR_M_ALL, `BSR_M_PERIPHERAL_IRQ_ENABLE_2, `BSR_M_ALL, `BSR_M_ALL,
		`BSR_M_TRANSMITTER_CONTROL_STATUS, `BSR_M_ALL, `BSR_M_ANALOG_PIN_CONFIG};
	localparam bsr_pkg::bsr_byte_t SR_RV [NS] = '{`BSR_RV_FF, `BSR_RV_PORT_A_DIRECTION, `BSR_RV_FF, `BSR_RV_FF,
		`BSR_RV_FF, `BSR_RV_SLAVE_PORT_AND_PORT_E_DIRECTION, `BSR_RV_00, `BSR_RV_00, `BSR_RV_00, `BSR_RV_FF, `BSR_RV_00,
		`BSR_RV_00, `BSR_RV_00, `BSR_RV_00};

	bsr_pkg::bsr_bus_state_t state_r;        // Bus phase
	bsr_pkg::bsr_byte_t      sreg_r [NS];    // Plain register storage
	logic [6:0]              off_r;          // Captured file offset
	logic                    rd_r;           // Captured direction
	logic                    be_r;           // Low byte lane enabled
	bsr_pkg::bsr_byte_t      wd_r;           // Captured write byte
	bsr_pkg::bsr_byte_t      tgt_r;          // Resolved target address
	logic                    gpr_r;          // Target is data memory
	bsr_pkg::bsr_byte_t      dir_addr;       // Direct address after bank route
	bsr_pkg::bsr_byte_t      eff_addr;       // Address after window resolve
	logic [2:0]              st_hi_r;        // Bank select bits 7:5
	logic [2:0]              zdc_r;          // Zero, digit carry, carry
	logic [6:0]              interrupt_control_hi_r;    // Enables and edge flags
	logic                    interrupt_control_lo_r;    // Port change flag
	bsr_pkg::bsr_byte_t      fsr_r;          // Indirect pointer
	bsr_pkg::bsr_byte_t      pcl_r;          // Program counter low
	logic                    power_rst;      // Brown-out class pulse
	logic                    other_rst;      // Pin or watchdog class pulse
	logic                    to_flag;        // Timeout flag
	logic                    pd_flag;        // Power-down flag
	bsr_pkg::bsr_byte_t      ram_q;          // Data memory read
	logic                    wr_now;         // Write commits this cycle
	logic                    any_rst;        // Either reset class
	logic                    win_mem;        // Window resolves into data memory; direct GPR offsets are holes

	// Fold common registers onto their bank-1 address
	function automatic bsr_pkg::bsr_byte_t canon(input bsr_pkg::bsr_byte_t a);
		logic [6:0] lo;
		lo = a[6:0];
		if (lo <= `BSR_OFS_FSR - `BSR_OFS_WINDOW || lo == `BSR_OFS_PC_UPPER_LATCH - `BSR_OFS_WINDOW ||
			lo == `BSR_OFS_INTERRUPT_CONTROL - `BSR_OFS_WINDOW) begin
			return {1'b1, lo};
		end
		return a;
	endfunction : canon

	// Data memory sits above the special registers in either bank
	function automatic logic is_gpr(input bsr_pkg::bsr_byte_t a);
		return a[6:0] >= `BSR_GPR_BASE;
	endfunction : is_gpr

	// Read value of a canonical special register address; holes give zero
	function automatic bsr_pkg::bsr_byte_t rd_sfr(input bsr_pkg::bsr_byte_t a);
		bsr_pkg::bsr_byte_t v;
		v = '0;
		for (int i = 0; i < NS; i++) begin
			if (a == SR_OFS[i]) begin
				v = sreg_r[i];
			end
		end
		unique case (a)
			`BSR_OFS_SLAVE_PORT_AND_PORT_E_DIRECTION:   v = v | {psp_flags_in, 5'h00};
			`BSR_OFS_TRANSMITTER_CONTROL_STATUS:   v = v | {6'h00, trmt_in, 1'b0};
			`BSR_OFS_STATUS:  v = arith_and_bank_status;
			`BSR_OFS_FSR:     v = fsr_r;
			`BSR_OFS_PCL:     v = pcl_r;
			`BSR_OFS_INTERRUPT_CONTROL:  v = {interrupt_control_hi_r, interrupt_control_lo_r};
			`BSR_OFS_RESET_CAUSE_FLAGS:    v = {6'h00, reset_cause_flags};
			`BSR_OFS_SERIAL_PORT_BUS_STATUS: v = {2'b00, serial_port_bus_status_in & `BSR_M_SERIAL_PORT_BUS_STATUS};
			default:          v = v;
		endcase
		return v;
	endfunction : rd_sfr

	// Reset class and hardware-only flags
	bsr_rst_flags u_rst (
		.ref_clk              (ref_clk),
		.nrst                 (nrst),
		.brown_out_reset      (brown_out_reset),
		.external_reset_pin_n (external_reset_pin_n),
		.wdt_reset            (wdt_reset),
		.sleep_exec           (sleep_exec),
		.clrwdt_exec          (clrwdt_exec),
		.reset_cause_flags_we              (wr_now && tgt_r == `BSR_OFS_RESET_CAUSE_FLAGS),
		.reset_cause_flags_wdata           (wd_r[1:0]),
		.power_rst_r          (power_rst),
		.other_rst_r          (other_rst),
		.timeout_flag_r       (to_flag),
		.power_down_flag_r    (pd_flag),
		.reset_cause_flags_r               (reset_cause_flags)
	);

	// Memory behind the window, read at the pointer at all times
	bsr_gpr_ram #(.AW(GPR_AW), .DW(8)) u_ram (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.rd_addr (fsr_r[GPR_AW-1:0]),
		.rd_q_r  (ram_q),
		.wr_en   (wr_now && gpr_r),
		.wr_addr (tgt_r[GPR_AW-1:0]),
		.wr_data (wd_r)
	);

	// Address routing; reserved upper bank bits are never looked at
	always_comb begin
		dir_addr = canon({st_hi_r[`BSR_ST_RP0-5], off_r});
		eff_addr = (dir_addr == `BSR_OFS_WINDOW) ? fsr_r : dir_addr;
		// Memory read port follows the pointer only, so only the window may reach memory
		win_mem  = dir_addr == `BSR_OFS_WINDOW && is_gpr(eff_addr);
	end
	assign any_rst = power_rst | other_rst;
	assign wr_now  = state_r == bsr_pkg::BSR_RESP && !rd_r && be_r;

	// Bus handshake: idle, resolve, answer with waitrequest low for one cycle
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_r         <= bsr_pkg::BSR_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata    <= '0;
			off_r           <= '0;
			rd_r            <= 1'b0;
			be_r            <= 1'b0;
			wd_r            <= '0;
			tgt_r           <= '0;
			gpr_r           <= 1'b0;
		end else begin
			unique case (state_r)
				bsr_pkg::BSR_IDLE: begin
					if (avs_read || avs_write) begin
						state_r <= bsr_pkg::BSR_ACC;
						off_r   <= avs_address[8:2];
						rd_r    <= avs_read;
						be_r    <= avs_byteenable[`BSR_BE_LOW];
						wd_r    <= avs_writedata[7:0];
					end
				end
				bsr_pkg::BSR_ACC: begin
					// Window pointing at itself resolves to a hole: reads zero, writes drop
					tgt_r           <= canon(eff_addr);
					gpr_r           <= win_mem;
					avs_readdata    <= {24'h000000, win_mem ? ram_q : rd_sfr(canon(eff_addr))};
					avs_waitrequest <= 1'b0;
					state_r         <= bsr_pkg::BSR_RESP;
				end
				bsr_pkg::BSR_RESP: begin
					avs_waitrequest <= 1'b1;
					state_r         <= bsr_pkg::BSR_IDLE;
				end
			endcase
		end
	end

	// Plain registers, one per loop pass
	for (genvar gi = 0; gi < NS; gi++) begin : g_sreg
		always_ff @(posedge ref_clk or negedge nrst) begin
			if (!nrst) begin
				sreg_r[gi] <= SR_RV[gi];
			end else if (any_rst) begin
				sreg_r[gi] <= SR_RV[gi];
			end else if (wr_now && tgt_r == SR_OFS[gi]) begin
				sreg_r[gi] <= wd_r & SR_WM[gi];
			end
		end
	end

	// Bank bits clear on every reset; flag bits kept on power and non-power resets alike
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_hi_r <= `BSR_RV_ST_HI;
			zdc_r   <= `BSR_RV_ZDC;
		end else if (power_rst) begin
			st_hi_r <= `BSR_RV_ST_HI;
		end else if (other_rst) begin
			st_hi_r <= `BSR_RV_ST_HI;
		end else begin
			if (wr_now && tgt_r == `BSR_OFS_STATUS) begin
				st_hi_r <= wd_r[7:5];
				zdc_r   <= wd_r[2:0];
			end
			// ALU result wins over a software write of the same bits
			if (alu_flags_we) begin
				zdc_r <= alu_flags;
			end
		end
	end

	// Pointer: undefined at power-up (zero here), kept otherwise
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			fsr_r <= '0;
		end else if (wr_now && tgt_r == `BSR_OFS_FSR) begin
			fsr_r <= wd_r;
		end
	end

	// Interrupt control: low flag kept on non-power resets
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			interrupt_control_hi_r <= `BSR_RV_INTERRUPT_CONTROL_HI;
			interrupt_control_lo_r <= 1'b0;
		end else if (any_rst) begin
			interrupt_control_hi_r <= `BSR_RV_INTERRUPT_CONTROL_HI;
		end else if (wr_now && tgt_r == `BSR_OFS_INTERRUPT_CONTROL) begin
			interrupt_control_hi_r <= wd_r[7:1];
			interrupt_control_lo_r <= wd_r[0];
		end
	end

	// Program counter low and jump; upper bits come only from the latch
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pcl_r       <= `BSR_RV_00;
			pc_jump_r   <= 1'b0;
			pc_target_r <= '0;
		end else if (any_rst) begin
			pcl_r       <= `BSR_RV_00;
			pc_jump_r   <= 1'b0;
		end else if (wr_now && tgt_r == `BSR_OFS_PCL) begin
			pcl_r       <= wd_r;
			pc_jump_r   <= 1'b1;
			pc_target_r <= {sreg_r[6][4:0], wd_r};
		end else begin
			pc_jump_r <= 1'b0;
			if (pc_low_we) begin
				pcl_r <= pc_low_in;
			end
		end
	end

	// Outputs straight from storage
	assign option_config                   = sreg_r[0];
	assign port_a_direction                = sreg_r[1];
	assign port_b_direction                = sreg_r[2];
	assign port_c_direction                = sreg_r[3];
	assign port_d_direction                = sreg_r[4];
	assign slave_port_and_port_e_direction = sreg_r[5];
	assign pc_upper_latch                  = sreg_r[6];
	assign peripheral_irq_enable_1         = sreg_r[7];
	assign peripheral_irq_enable_2         = sreg_r[8];
	assign timer2_period                   = sreg_r[9];
	assign serial_port_slave_address       = sreg_r[10];
	assign transmitter_control_status      = sreg_r[11];
	assign baud_divisor                    = sreg_r[12];
	assign analog_pin_config               = sreg_r[13];
	assign arith_and_bank_status           = {st_hi_r, to_flag, pd_flag, zdc_r};
	assign indirect_address_pointer        = fsr_r;
	assign interrupt_control               = {interrupt_control_hi_r, interrupt_control_lo_r};
	assign program_counter_low             = pcl_r;

	// Checks
	a_hole_reads_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		state_r == bsr_pkg::BSR_RESP && rd_r && tgt_r == `BSR_OFS_WINDOW |-> avs_readdata == '0)
		else $error("hole read not zero");
	a_pc_via_latch: assert property (@(posedge ref_clk) disable iff (!nrst)
		pc_jump_r |-> pc_target_r[12:8] == pc_upper_latch[4:0] && pc_target_r[7:0] == pcl_r)
		else $error("jump target not from latch");
	a_common_mirror: assert property (@(posedge ref_clk) disable iff (!nrst)
		state_r == bsr_pkg::BSR_ACC && off_r == 7'h03 |=> tgt_r == `BSR_OFS_STATUS)
		else $error("status not mirrored");
	a_power_reset_set: assert property (@(posedge ref_clk) disable iff (!nrst)
		power_rst |=> option_config == `BSR_RV_FF && port_a_direction == `BSR_RV_PORT_A_DIRECTION && st_hi_r == 3'h0)
		else $error("power reset values wrong");
	a_other_keeps_ptr: assert property (@(posedge ref_clk) disable iff (!nrst)
		other_rst && !wr_now |=> fsr_r == $past(fsr_r) && interrupt_control_lo_r == $past(interrupt_control_lo_r))
		else $error("pointer lost on warm reset");
	a_bank_route: assert property (@(posedge ref_clk) disable iff (!nrst)
		state_r == bsr_pkg::BSR_ACC && off_r == 7'h05 |=> tgt_r == {st_hi_r[0], 7'h05} || $past(any_rst))
		else $error("bank select ignored");
	a_flags_readonly: assert property (@(posedge ref_clk) disable iff (!nrst)
		wr_now && tgt_r == `BSR_OFS_STATUS && !brown_out_reset && !wdt_reset && !sleep_exec && !clrwdt_exec
		|=> arith_and_bank_status[4:3] == $past(arith_and_bank_status[4:3]))
		else $error("software moved timeout or power-down");
	a_window_memory: assert property (@(posedge ref_clk) disable iff (!nrst)
		state_r == bsr_pkg::BSR_RESP && rd_r && gpr_r |-> avs_readdata[7:0] == $past(ram_q, 1))
		else $error("window read not from memory");
	a_answer_time: assert property (@(posedge ref_clk) disable iff (!nrst)
		state_r == bsr_pkg::BSR_IDLE && (avs_read || avs_write) |=> ##1 !avs_waitrequest ##1 avs_waitrequest)
		else $error("answer late");
endmodule : bsr_bank1_regs

// ### hdl/bsr_cfg.svh
/*
 * Constants of the bank-1 special register block: offsets, masks, reset values and bit positions.
 * Assumes it is included by bare name from the design files; definitions only.
 */
`ifndef BSR_CFG_SVH
`define BSR_CFG_SVH

// Register offsets, full 8-bit file address
`define BSR_OFS_WINDOW   8'h80
`define BSR_OFS_OPTION   8'h81
`define BSR_OFS_PCL      8'h82
`define BSR_OFS_STATUS   8'h83
`define BSR_OFS_FSR      8'h84
`define BSR_OFS_PORT_A_DIRECTION    8'h85
`define BSR_OFS_PORT_B_DIRECTION    8'h86
`define BSR_OFS_PORT_C_DIRECTION    8'h87
`define BSR_OFS_PORT_D_DIRECTION    8'h88
`define BSR_OFS_SLAVE_PORT_AND_PORT_E_DIRECTION    8'h89
`define BSR_OFS_PC_UPPER_LATCH   8'h8A
`define BSR_OFS_INTERRUPT_CONTROL   8'h8B
`define BSR_OFS_PERIPHERAL_IRQ_ENABLE_1     8'h8C
`define BSR_OFS_PERIPHERAL_IRQ_ENABLE_2     8'h8D
`define BSR_OFS_RESET_CAUSE_FLAGS     8'h8E
`define BSR_OFS_PR2      8'h92
`define BSR_OFS_SERIAL_PORT_SLAVE_ADDRESS   8'h93
`define BSR_OFS_SERIAL_PORT_BUS_STATUS  8'h94
`define BSR_OFS_TRANSMITTER_CONTROL_STATUS    8'h98
`define BSR_OFS_BAUD_DIVISOR    8'h99
`define BSR_OFS_ANALOG_PIN_CONFIG   8'h9F

// Implemented-bit write masks
`define BSR_M_ALL        8'hFF
`define BSR_M_PORT_A_DIRECTION      8'h3F
`define BSR_M_SLAVE_PORT_AND_PORT_E_DIRECTION      8'h17
`define BSR_M_PC_UPPER_LATCH     8'h1F
`define BSR_M_PERIPHERAL_IRQ_ENABLE_2       8'h01
`define BSR_M_TRANSMITTER_CONTROL_STATUS      8'hF5
`define BSR_M_ANALOG_PIN_CONFIG     8'h07
`define BSR_M_SERIAL_PORT_BUS_STATUS    6'h3F

// Reset values of stored bits
`define BSR_RV_FF        8'hFF
`define BSR_RV_00        8'h00
`define BSR_RV_PORT_A_DIRECTION     8'h3F
`define BSR_RV_SLAVE_PORT_AND_PORT_E_DIRECTION     8'h07
`define BSR_RV_ST_HI     3'h0
`define BSR_RV_ZDC       3'h0
`define BSR_RV_INTERRUPT_CONTROL_HI 7'h00

// Field positions and decode limits
`define BSR_ST_RP0       5
`define BSR_ST_IRP       7
`define BSR_GPR_BASE     7'h20
`define BSR_SREG_N       14
`define BSR_BE_LOW       0

`endif

// ### hdl/bsr_gpr_ram.sv
/*
 * General purpose data memory reached through the indirect window.
 * Assumes one writer and a read address that is held steady by the caller.
 */
`timescale 1ns/1ns
module bsr_gpr_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic          ref_clk,
	input  wire logic          nrst,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_q_r,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data
);
	logic [DW-1:0] mem [2**AW]; // Storage, not reset

	// Write port; contents survive every reset like plain RAM
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read, one cycle behind the address
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_q_r <= '0;
		end else begin
			rd_q_r <= mem[rd_addr];
		end
	end
endmodule : bsr_gpr_ram

// ### hdl/bsr_pkg.sv
/*
 * Types of the bank-1 special register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bsr_pkg;
	// Register bus handshake phases
	typedef enum logic [1:0] {BSR_IDLE, BSR_ACC, BSR_RESP} bsr_bus_state_t;
	// One register byte
	typedef logic [7:0] bsr_byte_t;
endpackage : bsr_pkg

// ### hdl/bsr_rst_flags.sv
/*
 * Reset cause classifier and the timeout, power-down and reset-cause flags.
 * Assumes reset request inputs are synchronous pulses or levels from the core.
 */
`timescale 1ns/1ns
`include "bsr_cfg.svh"
module bsr_rst_flags (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       brown_out_reset,
	input  wire logic       external_reset_pin_n,
	input  wire logic       wdt_reset,
	input  wire logic       sleep_exec,
	input  wire logic       clrwdt_exec,
	input  wire logic       reset_cause_flags_we,
	input  wire logic [1:0] reset_cause_flags_wdata,
	output logic            power_rst_r,
	output logic            other_rst_r,
	output logic            timeout_flag_r,
	output logic            power_down_flag_r,
	output logic [1:0]      reset_cause_flags_r
);
	// Reset class pulses, one cycle late so the core sees them together
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			power_rst_r <= 1'b0;
			other_rst_r <= 1'b0;
		end else begin
			power_rst_r <= brown_out_reset;
			other_rst_r <= !external_reset_pin_n | wdt_reset;
		end
	end

	// Flags only hardware may move; no bus write reaches them
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			timeout_flag_r    <= 1'b1;
			power_down_flag_r <= 1'b1;
		end else if (brown_out_reset || clrwdt_exec) begin
			timeout_flag_r    <= 1'b1;
			power_down_flag_r <= 1'b1;
		end else if (wdt_reset) begin
			timeout_flag_r    <= 1'b0;
		end else if (sleep_exec) begin
			timeout_flag_r    <= 1'b1;
			power_down_flag_r <= 1'b0;
		end
	end

	// Cause flags: hardware clear wins over software set
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reset_cause_flags_r <= 2'b00;
		end else if (brown_out_reset) begin
			reset_cause_flags_r[0] <= 1'b0;
		end else if (reset_cause_flags_we) begin
			reset_cause_flags_r <= reset_cause_flags_wdata;
		end
	end
endmodule : bsr_rst_flags

// ### test/bank1_special_register_map_tb_top.sv
/*
 * Self-checking bench of the bank-1 register map: Avalon register accesses plus core events.
 * Assumes the design answers each request with one low cycle of waitrequest.
 */
`timescale 1ns/1ns
module bank1_special_register_map_tb_top;
	logic        ref_clk, nrst, avs_read, avs_write, avs_waitrequest;
	logic [8:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        bor, extn, wdt, slp, cwd, fwe, pwe, trmt, jump;
	logic [2:0]  fl, psp;
	logic [5:0]  ssp;
	logic [1:0]  cause;
	logic [12:0] target;
	logic [7:0]  pin, opt, dira, dirb, dirc, dird, dire, latch, ie1, ie2, t2per, sadd, txs, baud, adc, stat, ptr, intc;
	logic [7:0]  pclo;
	logic [7:0]  rdv; // Last read byte
	int          fail_count, n_checks;

	bsr_bank1_regs dut (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .brown_out_reset(bor),
		.external_reset_pin_n(extn), .wdt_reset(wdt), .sleep_exec(slp), .clrwdt_exec(cwd), .alu_flags_we(fwe),
		.alu_flags(fl), .pc_low_we(pwe), .pc_low_in(pin), .serial_port_bus_status_in(ssp), .trmt_in(trmt), .psp_flags_in(psp),
		.option_config(opt), .port_a_direction(dira), .port_b_direction(dirb), .port_c_direction(dirc),
		.port_d_direction(dird), .slave_port_and_port_e_direction(dire), .pc_upper_latch(latch),
		.peripheral_irq_enable_1(ie1), .peripheral_irq_enable_2(ie2), .timer2_period(t2per),
		.serial_port_slave_address(sadd), .transmitter_control_status(txs), .baud_divisor(baud),
		.analog_pin_config(adc), .arith_and_bank_status(stat), .indirect_address_pointer(ptr),
		.interrupt_control(intc), .program_counter_low(pclo), .reset_cause_flags(cause), .pc_jump_r(jump),
		.pc_target_r(target));
	bsr_core_model core (.ref_clk(ref_clk), .brown_out_reset(bor), .external_reset_pin_n(extn), .wdt_reset(wdt),
		.sleep_exec(slp), .clrwdt_exec(cwd), .alu_flags_we(fwe), .alu_flags(fl), .pc_low_we(pwe), .pc_low_in(pin),
		.serial_port_bus_status_in(ssp), .trmt_in(trmt), .psp_flags_in(psp));

	// Power-on reset value of each bank-1 location, unimplemented ones zero
	function automatic logic [7:0] rv(input logic [7:0] o);
		case (o)
			8'h81, 8'h86, 8'h87, 8'h88, 8'h92: rv = 8'hFF;
			8'h85: rv = 8'h3F;
			8'h89: rv = 8'h07;
			8'h98: rv = 8'h02;
			default: rv = 8'h00;
		endcase
	endfunction : rv

	// Read-back after writing all ones: implemented writable bits survive, and the read-only transmit status bit at 98h reads 1
	function automatic logic [7:0] mk(input logic [7:0] o);
		case (o)
			8'h81, 8'h86, 8'h87, 8'h88, 8'h8B, 8'h8C, 8'h92, 8'h93, 8'h99: mk = 8'hFF;
			8'h85: mk = 8'h3F;
			8'h89: mk = 8'h17;
			8'h8A: mk = 8'h1F;
			8'h8D: mk = 8'h01;
			8'h8E: mk = 8'h03;
			8'h98: mk = 8'hF7;
			8'h9F: mk = 8'h07;
			default: mk = 8'h00;
		endcase
	endfunction : mk

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address   <= {a[6:0], 2'b00};
		avs_read      <= ~wr;
		avs_write     <= wr;
		avs_writedata <= {24'h000000, wd};
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 32);
		if (n >= 32) begin
			chk("waitrequest", 8'h00, 8'h01);
		end
		rdv = avs_readdata[7:0];
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), exp, rdv);
	endtask : rd

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// 250 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Whole run is a few hundred cycles; this cuts a hang
	initial begin
		#40000;
		fail_count++;
		finish_test;
	end

	initial begin
		{nrst, avs_read, avs_write} = 3'b000;
		avs_address    = 9'h000;
		avs_writedata  = 32'h00000000;
		avs_byteenable = 4'hF;
		fail_count     = 0;
		n_checks       = 0;
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(8'h03, 8'h18);
		wr(8'h03, 8'h27);
		rd(8'h83, 8'h3F);
		wr(8'h83, 8'h20);
		// Bank-1 locations 81h to 9Fh except 82h to 84h: reset value, then surviving bits of an all-ones write
		for (int o = 8'h81; o <= 8'h9F; o++) begin
			if (o < 8'h82 || o > 8'h84) begin
				rd(8'(o), rv(8'(o)));
				wr(8'(o), 8'hFF);
				rd(8'(o), mk(8'(o)));
			end
		end
		avs_byteenable <= 4'hE;
		wr(8'h86, 8'h00);
		avs_byteenable <= 4'hF;
		rd(8'h86, 8'hFF);
		wr(8'h03, 8'h00);
		rd(8'h06, 8'h00);
		wr(8'h0A, 8'h13);
		rd(8'h0B, 8'hFF);
		wr(8'h03, 8'h20);
		rd(8'h8A, 8'h13);
		wr(8'h82, 8'h5A);
		for (int n = 0; n < 8 && jump !== 1'b1; n++) @(posedge ref_clk);
		chk("pc jump", 8'h01, {7'h00, jump});
		chk("pc hi", 8'h13, {3'b000, target[12:8]});
		chk("pc lo", 8'h5A, target[7:0]);
		// Window into data memory and, below 20h, onto a special register
		wr(8'h84, 8'h40);
		wr(8'h80, 8'hA5);
		wr(8'h84, 8'h41);
		wr(8'h80, 8'h5A);
		wr(8'h84, 8'h40);
		rd(8'h80, 8'hA5);
		rd(8'h40, 8'h00);
		wr(8'h84, 8'h00);
		rd(8'h80, 8'h00);
		wr(8'h84, 8'h8C);
		wr(8'h80, 8'h3C);
		rd(8'h8C, 8'h3C);
		wr(8'h84, 8'h77);
		wr(8'h86, 8'h00);
		core.core_op(3'b101, 8'h44);
		@(posedge ref_clk);
		chk("pc_low", 8'h44, pclo);
		chk("status", 8'h3D, stat);
		// Pin reset: plain registers reload, flags and pointer survive
		core.strobe(4);
		chk("status", 8'h1D, stat);
		chk("dirb", 8'hFF, dirb);
		chk("dira", 8'h3F, dira);
		chk("dirc", 8'hFF, dirc);
		chk("dird", 8'hFF, dird);
		chk("dire", 8'h07, dire);
		chk("ie1", 8'h00, ie1);
		chk("ie2", 8'h00, ie2);
		chk("t2per", 8'hFF, t2per);
		chk("sadd", 8'h00, sadd);
		chk("txs", 8'h00, txs);
		chk("baud", 8'h00, baud);
		chk("adc", 8'h00, adc);
		chk("ptr", 8'h77, ptr);
		chk("intc", 8'h01, intc);
		chk("pc_low", 8'h00, pclo);
		chk("latch", 8'h00, latch);
		chk("cause", 8'h03, {6'h00, cause});
		core.strobe(0);
		chk("status", 8'h15, stat);
		core.strobe(1);
		chk("status", 8'h1D, stat);
		core.strobe(2);
		chk("status", 8'h0D, stat);
		core.strobe(3);
		chk("status", 8'h1D, stat);
		chk("cause bor", 8'h00, {7'h00, cause[0]});
		chk("opt", 8'hFF, opt);
		finish_test;
	end
endmodule : bank1_special_register_map_tb_top

// ### test/bsr_core_model.sv
/*
 * Behavioural model of the processor core on the far side of the bank-1 register block.
 * Assumes the bench calls its tasks by hierarchy; every strobe changes just after a rising edge.
 */
`timescale 1ns/1ns
module bsr_core_model (
	input  wire logic ref_clk,
	output logic      brown_out_reset,
	output logic      external_reset_pin_n,
	output logic      wdt_reset,
	output logic      sleep_exec,
	output logic      clrwdt_exec,
	output logic      alu_flags_we,
	output logic [2:0] alu_flags,
	output logic      pc_low_we,
	output logic [7:0] pc_low_in,
	output logic [5:0] serial_port_bus_status_in,
	output logic      trmt_in,
	output logic [2:0] psp_flags_in
);
	// Idle core: no strobes, transmitter shift register empty
	initial begin
		{brown_out_reset, wdt_reset, sleep_exec, clrwdt_exec, alu_flags_we, pc_low_we} = 6'h00;
		external_reset_pin_n = 1'b1;
		alu_flags            = 3'h0;
		pc_low_in            = 8'h00;
		trmt_in              = 1'b1;
		serial_port_bus_status_in           = 6'h00;
		psp_flags_in         = 3'h0;
	end

	// One instruction that writes ALU flags and the program counter low byte
	task automatic core_op(input logic [2:0] f, input logic [7:0] p);
		@(posedge ref_clk);
		alu_flags_we <= 1'b1;
		alu_flags    <= f;
		pc_low_we    <= 1'b1;
		pc_low_in    <= p;
		@(posedge ref_clk);
		alu_flags_we <= 1'b0;
		pc_low_we    <= 1'b0;
	endtask : core_op

	// Sleep, clear-watchdog, watchdog, brown-out or pin reset; waits until the event has landed
	task automatic strobe(input int k);
		@(posedge ref_clk);
		case (k)
			0: sleep_exec <= 1'b1;
			1: clrwdt_exec <= 1'b1;
			2: wdt_reset <= 1'b1;
			3: brown_out_reset <= 1'b1;
			default: external_reset_pin_n <= 1'b0;
		endcase
		repeat (2) @(posedge ref_clk);
		{sleep_exec, clrwdt_exec, wdt_reset, brown_out_reset} <= 4'h0;
		external_reset_pin_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask : strobe
endmodule : bsr_core_model
